// ### src/ecr_pkg.sv
// ecr_pkg: constants and types for the ethernet clock and reset control block
// assumes one 125 MHz system clock; slower clocks are one-cycle enable pulses
// Summary of operation
// - low-latency variant drops receive fifos, leaving two datapath domains
// - transmit clock output follows transmit serdes reference, times tx stream
// - low-latency receive stream runs on recovered clock, unrelated to tx
// - 32-bit 10G variant keeps structure, stream clock at 312.5 MHz
// - mac-only uses one core clock, at least 156.25 MHz, for everything
// - negotiation and training exist only with BASE-KR, own clock domains
// - manchester frame on tx serdes clock, receive side on recovered clock
// - negotiation machine and abilities on negotiation clock, told its rate
// - stable helper clock, typically 75 MHz, helpers told its real rate
// - transceiver reset async active high, internal resets self-sequenced
// - transmit path reset affects only the transmit path
// - receive path reset affects only the receive path
// - sequencer lets all three resets release in one cycle safely

package ecr_pkg;

  localparam int         MCLK_MHZ      = 125;
  localparam logic [7:0] MCLK_MHZ8     = 8'(MCLK_MHZ);
  localparam logic [7:0] HLP_MHZ_TYP   = 8'h4B;
  localparam logic [6:0] PLL_RST_US    = 7'h02;
  localparam logic [6:0] LOCK_TMO_US   = 7'h64;
  localparam logic [9:0] NEG_MS_US     = 10'h3E8;
  localparam int         PATH_HOLD_NS  = 64;
  localparam logic [3:0] PATH_HOLD_CYC = 4'((PATH_HOLD_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [1:0] DOM_LOWLAT    = 2'h2;
  localparam logic [1:0] DOM_FIFO      = 2'h3;

  typedef enum logic [1:0] {SRC_TXREF, SRC_RXREC, SRC_CORE} ecr_src_t;
  typedef enum logic [1:0] {RATE_156, RATE_312, RATE_390} ecr_rate_t;
  typedef enum logic [2:0] {SQ_PLLRST, SQ_LOCK, SQ_TXUP, SQ_CDR, SQ_RUN} ecr_seq_t;

endpackage : ecr_pkg

// ### src/ecr_top.sv
// ecr_top: reset sequencing and clock-domain steering for the ethernet subsystem
// reset and lock pins are asynchronous; configuration comes from mclk_i logic
`timescale 1ns/1ps
`default_nettype none

module ecr_top (
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // asynchronous pins
  input  wire logic                transceiver_reset_i,
  input  wire logic                tx_reset_i,
  input  wire logic                rx_reset_i,
  input  wire logic                pll_lock_i,
  input  wire logic                cdr_lock_i,
  // variant configuration
  input  wire logic                cfg_low_lat_i,
  input  wire logic                cfg_mac_only_i,
  input  wire logic                cfg_kr_i,
  input  wire logic                cfg_w32_i,
  input  wire logic                cfg_r25_i,
  input  wire logic [7:0]          hlp_mhz_i,
  input  wire logic [7:0]          neg_mhz_i,
  input  wire logic [15:0]         ability_i,
  // transceiver sequencing
  output logic                     xcvr_pll_rst_o,
  output logic                     xcvr_tx_rst_o,
  output logic                     xcvr_rx_rst_o,
  output logic                     xcvr_done_o,
  // path resets
  output logic                     tx_path_rst_o,
  output logic                     rx_path_rst_o,
  // rate enables
  output logic                     hlp_tick_o,
  output logic                     us_tick_o,
  output logic                     neg_tick_o,
  output logic                     neg_ms_tick_o,
  output logic [15:0]              neg_ability_o,
  // domain steering
  output logic                     rx_fifo_en_o,
  output logic [1:0]               dp_domains_o,
  output var ecr_pkg::ecr_src_t    tx_stream_src_o,
  output var ecr_pkg::ecr_src_t    rx_stream_src_o,
  output var ecr_pkg::ecr_rate_t   stream_rate_o,
  output logic                     an_lt_en_o,
  output logic                     dme_tx_en_o,
  output logic                     an_rx_en_o,
  output var ecr_pkg::ecr_src_t    dme_src_o,
  output var ecr_pkg::ecr_src_t    an_rx_src_o
);
  import ecr_pkg::*;

  typedef struct packed {
    logic [4:0]  sy0;
    logic [4:0]  sy1;
    logic [7:0]  hacc;
    logic        htick;
    logic [7:0]  ucnt;
    logic        utick;
    logic [7:0]  nacc;
    logic        ntick;
    logic [7:0]  nucnt;
    logic [9:0]  mcnt;
    logic        mtick;
    logic [15:0] abil;
    ecr_seq_t    seq;
    logic [6:0]  tmr;
    logic        pll;
    logic        xtx;
    logic        xrx;
    logic        done;
    logic [3:0]  txh;
    logic [3:0]  rxh;
    logic        txr;
    logic        rxr;
    logic        ll;
    logic        mo;
    logic        kr;
    logic        w32;
    logic        r25;
    logic        fifo;
    logic [1:0]  dom;
    ecr_src_t    txsrc;
    ecr_src_t    rxsrc;
    ecr_rate_t   rate;
    logic        anen;
    logic        differential_manchester_frame;
    logic        anrx;
  } ecr_st_t;

  ecr_st_t st_ff;
  ecr_st_t nxt_st;

  // synchronised pin levels, second stage only
  logic xr_s;
  logic tr_s;
  logic rr_s;
  logic pl_s;
  logic cd_s;
  assign xr_s = st_ff.sy1[4];
  assign tr_s = st_ff.sy1[3];
  assign rr_s = st_ff.sy1[2];
  assign pl_s = st_ff.sy1[1];
  assign cd_s = st_ff.sy1[0];

  // fractional divider: mean tick rate is mhz out of MCLK_MHZ; {tick, acc}
  function automatic logic [8:0] acc_step(input logic [7:0] acc,
                                          input logic [7:0] mhz);
    logic [8:0] sum;
    sum = {1'b0, acc} + {1'b0, mhz};
    if (mhz >= MCLK_MHZ8) begin
      acc_step = 9'h100;
    end else if (sum >= {1'b0, MCLK_MHZ8}) begin
      acc_step = {1'b1, 8'(sum - {1'b0, MCLK_MHZ8})};
    end else begin
      acc_step = {1'b0, sum[7:0]};
    end
  endfunction : acc_step

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sy0 = {transceiver_reset_i, tx_reset_i, rx_reset_i, pll_lock_i, cdr_lock_i};
    nxt_st.sy1 = st_ff.sy0;

    {nxt_st.htick, nxt_st.hacc} = acc_step(st_ff.hacc, hlp_mhz_i);
    nxt_st.utick = 1'b0;
    if (st_ff.htick) begin
      if (st_ff.ucnt + 8'h01 >= hlp_mhz_i) begin
        nxt_st.ucnt  = 8'h00;
        nxt_st.utick = 1'b1;
      end else begin
        nxt_st.ucnt = st_ff.ucnt + 8'h01;
      end
    end

    // negotiation timers from its told rate
    {nxt_st.ntick, nxt_st.nacc} = acc_step(st_ff.nacc, neg_mhz_i);
    nxt_st.mtick = 1'b0;
    if (st_ff.ntick) begin
      nxt_st.abil = ability_i;
      if (st_ff.nucnt + 8'h01 >= neg_mhz_i) begin
        nxt_st.nucnt = 8'h00;
        if (st_ff.mcnt + 10'h001 >= NEG_MS_US) begin
          nxt_st.mcnt  = 10'h000;
          nxt_st.mtick = 1'b1;
        end else begin
          nxt_st.mcnt = st_ff.mcnt + 10'h001;
        end
      end else begin
        nxt_st.nucnt = st_ff.nucnt + 8'h01;
      end
    end

    if (st_ff.utick) begin
      nxt_st.tmr = st_ff.tmr + 7'h01;
    end
    case (st_ff.seq)
      SQ_PLLRST: begin
        // variant straps are only taken while the transceiver is held
        nxt_st.ll  = cfg_low_lat_i;
        nxt_st.mo  = cfg_mac_only_i;
        nxt_st.kr  = cfg_kr_i;
        nxt_st.w32 = cfg_w32_i;
        nxt_st.r25 = cfg_r25_i;
        if (st_ff.tmr >= PLL_RST_US) begin
          nxt_st.seq = SQ_LOCK;
          nxt_st.tmr = 7'h00;
        end
      end
      SQ_LOCK: begin
        if (pl_s) begin
          nxt_st.seq = SQ_TXUP;
        end else if (st_ff.tmr >= LOCK_TMO_US) begin
          nxt_st.seq = SQ_PLLRST;
          nxt_st.tmr = 7'h00;
        end
      end
      SQ_TXUP: begin
        nxt_st.seq = SQ_CDR;
      end
      SQ_CDR: begin
        if (!pl_s) begin
          nxt_st.seq = SQ_PLLRST;
          nxt_st.tmr = 7'h00;
        end else if (cd_s) begin
          nxt_st.seq = SQ_RUN;
        end
      end
      SQ_RUN: begin
        if (!pl_s) begin
          nxt_st.seq = SQ_PLLRST;
          nxt_st.tmr = 7'h00;
        end
      end
      default: begin
        nxt_st.seq = SQ_PLLRST;
        nxt_st.tmr = 7'h00;
      end
    endcase
    if (xr_s) begin
      nxt_st.seq = SQ_PLLRST;
      nxt_st.tmr = 7'h00;
    end
    nxt_st.pll  = (nxt_st.seq == SQ_PLLRST);
    nxt_st.xtx  = (nxt_st.seq == SQ_PLLRST) || (nxt_st.seq == SQ_LOCK);
    nxt_st.xrx  = (nxt_st.seq != SQ_RUN);
    nxt_st.done = (nxt_st.seq == SQ_RUN);

    // transmit path reset, own cause only
    if (tr_s || st_ff.xtx) begin
      nxt_st.txh = PATH_HOLD_CYC;
      nxt_st.txr = 1'b1;
    end else begin
      nxt_st.txr = (st_ff.txh != 4'h0);
      if (st_ff.txh != 4'h0) begin
        nxt_st.txh = st_ff.txh - 4'h1;
      end
    end
    // receive path reset, own cause only
    if (rr_s || st_ff.xrx) begin
      nxt_st.rxh = PATH_HOLD_CYC;
      nxt_st.rxr = 1'b1;
    end else begin
      nxt_st.rxr = (st_ff.rxh != 4'h0);
      if (st_ff.rxh != 4'h0) begin
        nxt_st.rxh = st_ff.rxh - 4'h1;
      end
    end

    // no receive fifo in low latency
    nxt_st.fifo = !st_ff.ll;
    nxt_st.dom  = st_ff.ll ? DOM_LOWLAT : DOM_FIFO;
    nxt_st.txsrc = st_ff.mo ? SRC_CORE : SRC_TXREF;
    if (st_ff.mo) begin
      nxt_st.rxsrc = SRC_CORE;
    end else if (st_ff.ll) begin
      nxt_st.rxsrc = SRC_RXREC;
    end else begin
      nxt_st.rxsrc = SRC_TXREF;
    end
    if (st_ff.w32) begin
      nxt_st.rate = RATE_312;
    end else if (st_ff.r25 && !st_ff.mo) begin
      nxt_st.rate = RATE_390;
    end else begin
      nxt_st.rate = RATE_156;
    end
    nxt_st.anen = st_ff.kr && !st_ff.mo;
    // frame sender waits for tx side
    nxt_st.differential_manchester_frame  = st_ff.anen && !st_ff.xtx;
    nxt_st.anrx = st_ff.anen && !st_ff.xrx;

    if (rst_i) begin
      nxt_st      = '0;
      nxt_st.pll  = 1'b1;
      nxt_st.xtx  = 1'b1;
      nxt_st.xrx  = 1'b1;
      nxt_st.txr  = 1'b1;
      nxt_st.rxr  = 1'b1;
      nxt_st.fifo = 1'b1;
      nxt_st.dom  = DOM_FIFO;
    end
  end

  always_ff @(posedge mclk_i) begin
    st_ff <= nxt_st;
  end

  assign xcvr_pll_rst_o  = st_ff.pll;
  assign xcvr_tx_rst_o   = st_ff.xtx;
  assign xcvr_rx_rst_o   = st_ff.xrx;
  assign xcvr_done_o     = st_ff.done;
  assign tx_path_rst_o   = st_ff.txr;
  assign rx_path_rst_o   = st_ff.rxr;
  assign hlp_tick_o      = st_ff.htick;
  assign us_tick_o       = st_ff.utick;
  assign neg_tick_o      = st_ff.ntick;
  assign neg_ms_tick_o   = st_ff.mtick;
  assign neg_ability_o   = st_ff.abil;
  assign rx_fifo_en_o    = st_ff.fifo;
  assign dp_domains_o    = st_ff.dom;
  assign tx_stream_src_o = st_ff.txsrc;
  assign rx_stream_src_o = st_ff.rxsrc;
  assign stream_rate_o   = st_ff.rate;
  assign an_lt_en_o      = st_ff.anen;
  assign dme_tx_en_o     = st_ff.differential_manchester_frame;
  assign an_rx_en_o      = st_ff.anrx;
  assign dme_src_o       = SRC_TXREF;
  assign an_rx_src_o     = SRC_RXREC;

  property p_lowlat;
    @(posedge mclk_i) disable iff (rst_i)
      st_ff.ll |=> !rx_fifo_en_o && dp_domains_o == DOM_LOWLAT;
  endproperty
  a_lowlat: assert property (p_lowlat) else $error("fifo kept in low latency");

  property p_txsrc;
    @(posedge mclk_i) disable iff (rst_i)
      !st_ff.mo |=> tx_stream_src_o == SRC_TXREF;
  endproperty
  a_txsrc: assert property (p_txsrc) else $error("tx stream not on reference");

  property p_rxsrc;
    @(posedge mclk_i) disable iff (rst_i)
      st_ff.ll && !st_ff.mo |=> rx_stream_src_o == SRC_RXREC;
  endproperty
  a_rxsrc: assert property (p_rxsrc) else $error("rx stream not recovered");

  property p_rate32;
    @(posedge mclk_i) disable iff (rst_i)
      st_ff.w32 |=> stream_rate_o == RATE_312;
  endproperty
  a_rate32: assert property (p_rate32) else $error("narrow rate wrong");

  property p_core;
    @(posedge mclk_i) disable iff (rst_i)
      st_ff.mo |=> tx_stream_src_o == SRC_CORE && rx_stream_src_o == SRC_CORE;
  endproperty
  a_core: assert property (p_core) else $error("mac-only not on core");

  property p_kronly;
    @(posedge mclk_i) disable iff (rst_i)
      !an_lt_en_o |-> !dme_tx_en_o && !an_rx_en_o;
  endproperty
  a_kronly: assert property (p_kronly) else $error("negotiation without option");

  property p_dme;
    @(posedge mclk_i) disable iff (rst_i)
      dme_tx_en_o |-> $past(!xcvr_tx_rst_o);
  endproperty
  a_dme: assert property (p_dme) else $error("frame sent under tx reset");

  property p_seq;
    @(posedge mclk_i) disable iff (rst_i)
      xcvr_done_o |-> !xcvr_pll_rst_o && !xcvr_tx_rst_o && !xcvr_rx_rst_o;
  endproperty
  a_seq: assert property (p_seq) else $error("done with reset held");

  property p_txiso;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(tx_path_rst_o) |-> $past(tr_s || xcvr_tx_rst_o);
  endproperty
  a_txiso: assert property (p_txiso) else $error("tx reset from foreign cause");

  property p_rxiso;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(rx_path_rst_o) |-> $past(rr_s || xcvr_rx_rst_o);
  endproperty
  a_rxiso: assert property (p_rxiso) else $error("rx reset from foreign cause");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
      $fell(tx_path_rst_o) |-> !$past(xcvr_tx_rst_o, 8) && $past(xcvr_tx_rst_o) == 1'b0;
  endproperty
  a_hold: assert property (p_hold) else $error("tx released too early");

  property p_sync;
    @(posedge mclk_i) disable iff (rst_i)
      tx_reset_i |-> ##3 tx_path_rst_o;
  endproperty
  a_sync: assert property (p_sync) else $error("tx reset not taken");

  c_run:    cover property (@(posedge mclk_i) disable iff (rst_i) $rose(xcvr_done_o));
  c_txonly: cover property (@(posedge mclk_i) disable iff (rst_i)
                            tx_path_rst_o && !rx_path_rst_o);
  c_dme:    cover property (@(posedge mclk_i) disable iff (rst_i) $rose(dme_tx_en_o));

endmodule : ecr_top

`default_nettype wire

// ### sim/ecr_xcvr_model.sv
// ecr_xcvr_model: behavioural transceiver lock model for the clock and reset bench
// assumes it shares the system clock; lock delay is set by the bench per run
`timescale 1ns/1ps
`default_nettype none

module ecr_xcvr_model (
  // clock
  input  wire logic       mclk_i,
  // transceiver resets from the sequencer
  input  wire logic       pll_rst_i,
  input  wire logic       tx_rst_i,
  input  wire logic [7:0] lock_dly_i,
  // lock indications
  output logic            pll_lock_o,
  output logic            cdr_lock_o
);
  logic [7:0] pll_cnt;
  logic [7:0] cdr_cnt;

  initial begin
    pll_lock_o = 1'b0;
    cdr_lock_o = 1'b0;
    pll_cnt    = 8'h00;
    cdr_cnt    = 8'h00;
  end

  // lock is lost at once when the pll is held, never kept across a reset
  always @(posedge mclk_i) begin
    #1;
    if (pll_rst_i) begin
      pll_cnt = 8'h00;
      cdr_cnt = 8'h00;
    end else begin
      if (pll_cnt < lock_dly_i) pll_cnt = pll_cnt + 8'h01;
      if (!tx_rst_i && cdr_cnt < lock_dly_i) cdr_cnt = cdr_cnt + 8'h01;
    end
    pll_lock_o = !pll_rst_i && (pll_cnt >= lock_dly_i);
    cdr_lock_o = !pll_rst_i && !tx_rst_i && (cdr_cnt >= lock_dly_i);
  end
endmodule : ecr_xcvr_model

`default_nettype wire

// ### sim/ecr_top_tb.sv
// ecr_top_tb: self-checking bench for the clock and reset control block
// assumes the transceiver model above; expectations queued, checked by a monitor
`timescale 1ns/1ps
`default_nettype none

module ethernet_clock_reset_domains_tb;
  import ecr_pkg::*;

  typedef struct {string nm; int sel; logic [15:0] exp;} ecr_note_t;
  ecr_note_t   notes[$];
  int          num_errors = 0;
  int          tests_run  = 0;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        xrst = 1'b0, txr = 1'b0, rxr = 1'b0, pll_lock, cdr_lock;
  logic [4:0]  cfg = 5'h00;
  logic [7:0]  hlp_mhz = 8'h7D, neg_mhz = 8'h7D, dly = 8'h01;
  logic [15:0] ability = 16'h0000;
  logic        pll_rst, xtx_rst, xrx_rst, done, tx_prst, rx_prst;
  logic        hlp_tick, us_tick, neg_tick, ms_tick, fifo_en, an_en, dme_en, anrx_en;
  logic [15:0] neg_ab;
  logic [1:0]  doms;
  ecr_src_t    tx_src, rx_src, dme_src, anrx_src;
  ecr_rate_t   rate;
  int          n_neg, n_hlp, n_us, n_ms;
  logic        ok;

  always #4 mclk_i = ~mclk_i;

  ecr_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .transceiver_reset_i(xrst),
    .tx_reset_i(txr), .rx_reset_i(rxr), .pll_lock_i(pll_lock), .cdr_lock_i(cdr_lock),
    .cfg_low_lat_i(cfg[4]), .cfg_mac_only_i(cfg[3]), .cfg_kr_i(cfg[2]), .cfg_w32_i(cfg[1]),
    .cfg_r25_i(cfg[0]), .hlp_mhz_i(hlp_mhz), .neg_mhz_i(neg_mhz), .ability_i(ability),
    .xcvr_pll_rst_o(pll_rst), .xcvr_tx_rst_o(xtx_rst), .xcvr_rx_rst_o(xrx_rst),
    .xcvr_done_o(done), .tx_path_rst_o(tx_prst), .rx_path_rst_o(rx_prst),
    .hlp_tick_o(hlp_tick), .us_tick_o(us_tick), .neg_tick_o(neg_tick),
    .neg_ms_tick_o(ms_tick), .neg_ability_o(neg_ab), .rx_fifo_en_o(fifo_en),
    .dp_domains_o(doms), .tx_stream_src_o(tx_src), .rx_stream_src_o(rx_src),
    .stream_rate_o(rate), .an_lt_en_o(an_en), .dme_tx_en_o(dme_en), .an_rx_en_o(anrx_en),
    .dme_src_o(dme_src), .an_rx_src_o(anrx_src));

  ecr_xcvr_model u_xcvr (.mclk_i(mclk_i), .pll_rst_i(pll_rst), .tx_rst_i(xtx_rst),
    .lock_dly_i(dly), .pll_lock_o(pll_lock), .cdr_lock_o(cdr_lock));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: obs = {15'h0000, tx_prst};
      1: obs = {15'h0000, rx_prst};
      2: obs = {15'h0000, fifo_en};
      3: obs = {14'h0000, doms};
      4: obs = {14'h0000, tx_src};
      5: obs = {14'h0000, rx_src};
      6: obs = {14'h0000, rate};
      7: obs = {15'h0000, an_en};
      8: obs = neg_ab;
      9: obs = {15'h0000, done};
      10: obs = {12'h0000, dme_src, anrx_src};
      11: obs = {14'h0000, dme_en, anrx_en};
      13: obs = {13'h0000, pll_rst, xtx_rst, xrx_rst};
      default: obs = {15'h0000, ok};
    endcase
  endfunction : obs

  // a note posted 1 ns after an edge is checked 2 ns after that same edge
  task automatic note(input string nm, input int sel, input logic [15:0] exp);
    notes.push_back('{nm, sel, exp});
  endtask : note

  always @(posedge mclk_i) begin
    #2;
    while (notes.size() > 0) begin
      ecr_note_t n;
      n = notes.pop_front();
      check(n.nm, obs(n.sel), n.exp);
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic wait_done();
    int i;
    for (i = 0; i < 4000 && done !== 1'b1; i++) cyc(1);
    if (done !== 1'b1) num_errors++;
  endtask : wait_done

  task automatic test_done();
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    #480000;
    num_errors++;
    test_done();
  end

  logic [4:0] cfgs[5] = '{5'h11, 5'h00, 5'h0C, 5'h12, 5'h05};

  initial begin
    void'($urandom(32'h4938_0572));
    cyc(16);
    rst_i = 1'b0;
    foreach (cfgs[c]) begin
      cfg = cfgs[c];
      dly = 8'(1 + $urandom % 200);
      xrst = 1'b1;
      cyc(3);
      xrst = 1'b0;
      wait_done();
      cyc(20);
      note("fifo", 2, {15'h0000, !cfg[4]});
      note("domains", 3, cfg[4] ? 16'h0002 : 16'h0003);
      note("tx_src", 4, cfg[3] ? 16'(SRC_CORE) : 16'(SRC_TXREF));
      if (cfg[4]) note("rx_src", 5, 16'(SRC_RXREC));
      if (cfg[3]) note("rx_src", 5, 16'(SRC_CORE));
      if (cfg[4:3] == 2'b00) note("rx_src", 5, 16'(SRC_TXREF));
      note("rate", 6, cfg[1] ? 16'(RATE_312) :
        (cfg[0] && !cfg[3]) ? 16'(RATE_390) : 16'(RATE_156));
      note("an_en", 7, {15'h0000, cfg[2] && !cfg[3]});
      note("neg_src", 10, {12'h0000, SRC_TXREF, SRC_RXREC});
      note("neg_en", 11, {14'h0000, {2{cfg[2] && !cfg[3]}}});
      note("tx_prst", 0, 16'h0000);
      note("xcvr_rst", 13, 16'h0000);
      cyc(1);
    end
    for (int p = 0; p < 2; p++) begin
      txr = (p == 0);
      rxr = (p == 1);
      cyc(3);
      note("tx_prst", 0, {15'h0000, p == 0});
      note("rx_prst", 1, {15'h0000, p == 1});
      note("done", 9, 16'h0001);
      cyc(3);
      txr = 1'b0;
      rxr = 1'b0;
      cyc(8);
      note("held", p, 16'h0001);
      cyc(3);
      note("freed", p, 16'h0000);
      cyc(2);
    end
    {xrst, txr, rxr} = 3'h7;
    cyc(5);
    note("xcvr_held", 13, 16'h0007);
    {xrst, txr, rxr} = 3'h0;
    wait_done();
    cyc(20);
    note("tx_prst", 0, 16'h0000);
    note("rx_prst", 1, 16'h0000);
    ability = 16'($urandom);
    cyc(4);
    note("ability", 8, ability);
    cyc(1);
    neg_mhz = 8'(1 + $urandom % 124);
    hlp_mhz = 8'(1 + $urandom % 124);
    cyc(4);
    n_neg = 0;
    n_hlp = 0;
    n_us  = 0;
    n_ms  = 0;
    repeat (1000) begin
      @(posedge mclk_i);
      #1;
      n_neg += int'(neg_tick === 1'b1);
      n_hlp += int'(hlp_tick === 1'b1);
      n_us  += int'(us_tick === 1'b1);
      n_ms  += int'(ms_tick === 1'b1);
    end
    // signed arithmetic, so a short count cannot wrap into a pass or a false fail
    ok = (n_neg - 8 * int'(neg_mhz) <= 1) && (8 * int'(neg_mhz) - n_neg <= 1);
    note("neg_rate", 12, 16'h0001);
    cyc(1);
    ok = (n_hlp - 8 * int'(hlp_mhz) <= 1) && (8 * int'(hlp_mhz) - n_hlp <= 1);
    note("hlp_rate", 12, 16'h0001);
    cyc(1);
    ok = (n_us >= 7) && (n_us <= 9);
    note("us_rate", 12, 16'h0001);
    cyc(1);
    ok = (n_ms <= 1);
    note("ms_rate", 12, 16'h0001);
    cyc(2);
    test_done();
  end
endmodule : ethernet_clock_reset_domains_tb

`default_nettype wire
